// file: core/slmi_params.svh
`ifndef SLMI_PARAMS_SVH
`define SLMI_PARAMS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SLMI_OFF_CMD     8'h00
`define SLMI_OFF_LEVEL   8'h04
`define SLMI_OFF_RANGE   8'h08
`define SLMI_OFF_DELAY   8'h0c
`define SLMI_OFF_FIRST   8'h10
`define SLMI_OFF_LAST    8'h14
`define SLMI_OFF_STSEL   8'h18
`define SLMI_OFF_STWORD  8'h1c
`define SLMI_OFF_ERR     8'h20
`define SLMI_OFF_WARN    8'h24
`define SLMI_OFF_SWCFG   8'h28
`define SLMI_OFF_TEXT    8'h2c
`define SLMI_OFF_MPAR    8'h30
`define SLMI_OFF_SUPV    8'h34
`define SLMI_OFF_TRIG    8'h38
`define SLMI_OFF_READING 8'h3c
`define SLMI_OFF_INDEX   8'h40
`define SLMI_OFF_PTSEL   8'h44
`define SLMI_OFF_PTLVL   8'h48
`define SLMI_OFF_PTRD    8'h4c

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SLMI_CMD_VAL_BIT     4
`define SLMI_ERR_ILLEGAL_BIT 0
`define SLMI_ERR_VALUE_BIT   1
`define SLMI_WRN_CREATE_BIT  0
`define SLMI_WRN_RANGE_BIT   1
`define SLMI_CFG_VOLT_BIT    16
`define SLMI_CFG_PULSED_BIT  17
`define SLMI_MS_HV_BIT       0
`define SLMI_MS_DD_BIT       1
`define SLMI_MS_SUP_BIT      2
`define SLMI_MS_VOLT_BIT     3
`define SLMI_MS_PULSED_BIT   4
`define SLMI_MS_RECALC_BIT   5
`define SLMI_MS_BUSY_BIT     6

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define SLMI_INDEX_RST  10'h001
`define SLMI_MIN_INDEX  32'h0000_0001
`define SLMI_MAX_INDEX  32'd1000
`define SLMI_MAX_DELAY  32'd65000
`define SLMI_I_BASE     32'd1
`define SLMI_V_BASE     32'd1100000
`define SLMI_I_LIM      32'd100000000
`define SLMI_I_LIM_HC   32'd1000000000
`define SLMI_V_LIM      32'd110000000
`define SLMI_V_LIM_HV   32'd1100000000
`define SLMI_RESP_OKAY  2'h0
`define SLMI_RESP_SLV   2'h2

`endif

// file: core/slmi_pkg.sv
package slmi_pkg;

  // ------------------------------------------------------------
  // Command codes and states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    SLMI_OP_NONE    = 4'h0,
    SLMI_OP_MODIFY  = 4'h1,
    SLMI_OP_HVR     = 4'h2,
    SLMI_OP_DDLY    = 4'h3,
    SLMI_OP_SUPP    = 4'h4,
    SLMI_OP_RESTORE = 4'h5,
    SLMI_OP_EXEC    = 4'h6
  } slmi_op_t;

  typedef enum logic [0:0] {SLMI_IDLE, SLMI_APPLY} slmi_state_t;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] level;
    logic [3:0]  range_code;
    logic [15:0] delay;
  } slmi_point_t;

  typedef struct packed {
    logic [31:0] level;
    logic [31:0] range_code;
    logic [31:0] delay;
    logic [31:0] first;
    logic [31:0] last;
    logic        has_level;
    logic        has_range;
    logic        has_delay;
    logic        has_first;
    logic        has_last;
  } slmi_cmd_t;

  typedef struct packed {
    logic [31:0] compliance;
    logic [31:0] calibration;
    logic [31:0] first_comp;
    logic [31:0] meas_size;
  } slmi_ext_t;

  typedef struct packed {
    logic       range_bad;
    logic       level_bad;
    logic       fits_present;
    logic [3:0] auto_range;
  } slmi_chk_t;

endpackage

// file: core/slmi_check.sv
`timescale 1ns/1ps
`include "slmi_params.svh"
module slmi_check import slmi_pkg::*; #(
  parameter bit HIGH_CURRENT = 1'b0,
  parameter bit HIGH_VOLTAGE = 1'b0
) (
  // Point under test
  input  wire logic [31:0] level,
  input  wire logic [3:0]  range_code,
  input  wire logic [3:0]  present,
  // Mode
  input  wire logic        volt,
  input  wire logic        hv_en,
  // Verdict
  output slmi_chk_t        chk
);

  // ------------------------------------------------------------
  // Decade full scale of a range code
  // ------------------------------------------------------------
  function automatic logic [31:0] full_scale(input logic v, input logic [3:0] code);
    logic [31:0] fs;
    fs = v ? `SLMI_V_BASE : `SLMI_I_BASE;
    for (int i = 1; i < 10; i++) begin
      if (4'(i) < code) fs = 32'(fs * 32'd10);
    end
    return fs;
  endfunction

  logic [31:0] mag;
  logic [31:0] lim;
  logic [3:0]  top_code;

  always_comb begin
    mag = level[31] ? 32'(-level) : level;
    if (volt) begin
      top_code = (HIGH_VOLTAGE && hv_en) ? 4'h4 : 4'h3;
      lim      = (HIGH_VOLTAGE && hv_en) ? `SLMI_V_LIM_HV : `SLMI_V_LIM;
    end else begin
      top_code = HIGH_CURRENT ? 4'ha : 4'h9;
      lim      = HIGH_CURRENT ? `SLMI_I_LIM_HC : `SLMI_I_LIM;
    end
    chk.range_bad  = range_code > top_code;
    chk.level_bad  = mag > lim;
    // Smallest range that holds the level gives the finest resolution
    chk.auto_range = top_code;
    for (int k = 10; k >= 1; k--) begin
      if (4'(k) <= top_code && full_scale(volt, 4'(k)) >= mag) chk.auto_range = 4'(k);
    end
    chk.fits_present = (present == 4'h0) ||
                       (present <= top_code && mag <= full_scale(volt, present));
  end

endmodule

// file: core/slmi_top.sv
`timescale 1ns/1ps
`include "slmi_params.svh"
module slmi_top import slmi_pkg::*; #(
  parameter int          DEPTH        = 1000,
  parameter bit          HIGH_CURRENT = 1'b0,
  parameter bit          HIGH_VOLTAGE = 1'b0,
  parameter logic [31:0] MODEL_ID     = 32'h0000_0a5c  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Write address and data
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // Write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // Read address and data
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Bus device clear
  input  wire logic        DEV_CLEAR,
  // Measurement path
  output logic             MEAS_TRIG,
  input  wire logic        MEAS_VALID,
  input  wire logic [31:0] MEAS_DATA,
  input  wire slmi_ext_t   EXT_STATUS
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                aw_addr;
    logic                      aw_have;
    logic [31:0]               w_data;
    logic [3:0]                w_strb;
    logic                      w_have;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic [7:0]                ar_addr;
    logic                      ar_have;
    logic                      rvalid;
    logic [1:0]                rresp;
    logic [31:0]               rdata;
    slmi_cmd_t                 cmd;
    slmi_cmd_t                 ap;
    logic                      pend_mod;
    logic                      pend_hv;
    logic                      pend_hv_val;
    logic                      pend_dd;
    logic                      pend_dd_val;
    logic                      pend_sup;
    logic                      pend_sup_val;
    logic                      pend_restore;
    logic                      hv_en;
    logic                      dd_en;
    logic                      sup_en;
    logic [9:0]                first_idx;
    logic [9:0]                last_idx;
    logic [1:0]                err;
    logic [1:0]                warn;
    logic [10:0]               sweep_size;
    logic                      volt;
    logic                      pulsed;
    logic                      recalc;
    logic [3:0]                st_sel;
    logic [31:0]               text;
    logic [31:0]               mpar;
    logic [31:0]               supv;
    logic                      meas_busy;
    logic                      meas_trig;
    logic [31:0]               reading;
    logic [9:0]                pt_sel;
    slmi_state_t               state;
    logic [9:0]                idx;
    logic [9:0]                stop;
    slmi_point_t [DEPTH-1:0]   pts;
  } slmi_regs_t;

  slmi_regs_t  r;
  slmi_regs_t  n;
  slmi_chk_t   chk;
  slmi_point_t cur;
  logic [31:0] chk_level;
  logic [3:0]  chk_range;

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= `SLMI_OFF_PTRD;
  endfunction

  function automatic logic [31:0] status_word(input logic [3:0] sel);
    logic [31:0] ms;
    ms = '0;
    ms[`SLMI_MS_HV_BIT]     = r.hv_en;
    ms[`SLMI_MS_DD_BIT]     = r.dd_en;
    ms[`SLMI_MS_SUP_BIT]    = r.sup_en;
    ms[`SLMI_MS_VOLT_BIT]   = r.volt;
    ms[`SLMI_MS_PULSED_BIT] = r.pulsed;
    ms[`SLMI_MS_RECALC_BIT] = r.recalc;
    ms[`SLMI_MS_BUSY_BIT]   = (r.state == SLMI_APPLY);
    case (sel)
      4'h0: return MODEL_ID;
      4'h1: return {30'h0, r.err};
      4'h2: return r.text;
      4'h3: return ms;
      4'h4: return r.mpar;
      4'h5: return EXT_STATUS.compliance;
      4'h6: return r.supv;
      4'h7: return EXT_STATUS.calibration;
      4'h8: return {21'h0, r.sweep_size};
      4'h9: return {30'h0, r.warn};
      4'ha: return EXT_STATUS.first_comp;
      4'hb: return EXT_STATUS.meas_size;
      default: return 32'h0;
    endcase
  endfunction

  function automatic logic [31:0] image(input logic [7:0] a);
    slmi_point_t p;
    p = r.pts[r.pt_sel];
    case (a)
      `SLMI_OFF_LEVEL:   return r.cmd.level;
      `SLMI_OFF_RANGE:   return r.cmd.range_code;
      `SLMI_OFF_DELAY:   return r.cmd.delay;
      `SLMI_OFF_FIRST:   return r.cmd.first;
      `SLMI_OFF_LAST:    return r.cmd.last;
      `SLMI_OFF_STSEL:   return {28'h0, r.st_sel};
      `SLMI_OFF_STWORD:  return status_word(r.st_sel);
      `SLMI_OFF_ERR:     return {30'h0, r.err};
      `SLMI_OFF_WARN:    return {30'h0, r.warn};
      `SLMI_OFF_SWCFG:   return {14'h0, r.pulsed, r.volt, 5'h0, r.sweep_size};
      `SLMI_OFF_TEXT:    return r.text;
      `SLMI_OFF_MPAR:    return r.mpar;
      `SLMI_OFF_SUPV:    return r.supv;
      `SLMI_OFF_READING: return r.reading;
      `SLMI_OFF_INDEX:   return {6'h0, r.last_idx, 6'h0, r.first_idx};
      `SLMI_OFF_PTSEL:   return {22'h0, r.pt_sel};
      `SLMI_OFF_PTLVL:   return p.level;
      `SLMI_OFF_PTRD:    return {12'h0, p.range_code, p.delay};
      default:           return 32'h0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) m[b*8 +: 8] = nw[b*8 +: 8];
    end
    return m;
  endfunction

  // ------------------------------------------------------------
  // Level and range checks
  // ------------------------------------------------------------
  assign cur       = r.pts[r.idx];
  assign chk_level = (r.state == SLMI_IDLE || r.ap.has_level) ? 
                     ((r.state == SLMI_IDLE) ? r.cmd.level : r.ap.level) : cur.level;
  assign chk_range = (r.state == SLMI_IDLE) ? r.cmd.range_code[3:0] : r.ap.range_code[3:0];

  slmi_check #(
    .HIGH_CURRENT (HIGH_CURRENT),
    .HIGH_VOLTAGE (HIGH_VOLTAGE)
  ) u_check (
    .level      (chk_level),
    .range_code ((r.state == SLMI_IDLE && r.cmd.range_code[31:4] != 28'h0) ? 4'hf : chk_range),
    .present    (cur.range_code),
    .volt       (r.volt),
    .hv_en      (r.hv_en),
    .chk        (chk)
  );

  assign S_AXI_AWREADY = !r.aw_have && !r.bvalid;
  assign S_AXI_WREADY  = !r.w_have && !r.bvalid;
  assign S_AXI_ARREADY = !r.ar_have && !r.rvalid;
  assign S_AXI_BVALID  = r.bvalid;
  assign S_AXI_BRESP   = r.bresp;
  assign S_AXI_RVALID  = r.rvalid;
  assign S_AXI_RRESP   = r.rresp;
  assign S_AXI_RDATA   = r.rdata;
  assign MEAS_TRIG     = r.meas_trig;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic        exec;
    logic [31:0] lst;
    slmi_point_t p;
    wv   = merge(image(r.aw_addr), r.w_data, r.w_strb);
    exec = 1'b0;
    lst  = r.cmd.has_last ? r.cmd.last : r.cmd.first;
    p    = cur;
    n    = r;
    n.meas_trig = 1'b0;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      n.aw_addr = S_AXI_AWADDR;
      n.aw_have = 1'b1;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      n.w_data = S_AXI_WDATA;
      n.w_strb = S_AXI_WSTRB;
      n.w_have = 1'b1;
    end
    if (r.bvalid && S_AXI_BREADY) n.bvalid = 1'b0;
    if (MEAS_VALID && r.meas_busy) begin
      n.reading   = MEAS_DATA;
      n.meas_busy = 1'b0;
    end
    // Writes wait while a run is applied, so staging never races it
    if (r.aw_have && r.w_have && !r.bvalid && r.state == SLMI_IDLE) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = mapped(r.aw_addr) ? `SLMI_RESP_OKAY : `SLMI_RESP_SLV;
      case (r.aw_addr)
        `SLMI_OFF_CMD: begin
          case (wv[3:0])
            SLMI_OP_MODIFY:  n.pend_mod = 1'b1;
            SLMI_OP_HVR: begin
              n.pend_hv     = 1'b1;
              n.pend_hv_val = wv[`SLMI_CMD_VAL_BIT];
            end
            SLMI_OP_DDLY: begin
              n.pend_dd     = 1'b1;
              n.pend_dd_val = wv[`SLMI_CMD_VAL_BIT];
            end
            SLMI_OP_SUPP: begin
              n.pend_sup     = 1'b1;
              n.pend_sup_val = wv[`SLMI_CMD_VAL_BIT];
            end
            SLMI_OP_RESTORE: n.pend_restore = 1'b1;
            SLMI_OP_EXEC:    exec = 1'b1;
            default: ;
          endcase
        end
        `SLMI_OFF_LEVEL: {n.cmd.level, n.cmd.has_level} = {wv, 1'b1};
        `SLMI_OFF_RANGE: {n.cmd.range_code, n.cmd.has_range} = {wv, 1'b1};
        `SLMI_OFF_DELAY: {n.cmd.delay, n.cmd.has_delay} = {wv, 1'b1};
        `SLMI_OFF_FIRST: {n.cmd.first, n.cmd.has_first} = {wv, 1'b1};
        `SLMI_OFF_LAST:  {n.cmd.last, n.cmd.has_last} = {wv, 1'b1};
        `SLMI_OFF_STSEL: n.st_sel = wv[3:0];
        `SLMI_OFF_ERR:   n.err = r.err & ~wv[1:0];
        `SLMI_OFF_WARN:  n.warn = r.warn & ~wv[1:0];
        `SLMI_OFF_SWCFG: begin
          n.sweep_size = wv[10:0];
          n.volt       = wv[`SLMI_CFG_VOLT_BIT];
          n.pulsed     = wv[`SLMI_CFG_PULSED_BIT];
          n.recalc     = 1'b1;
        end
        `SLMI_OFF_TEXT:  n.text = wv;
        `SLMI_OFF_MPAR:  n.mpar = wv;
        `SLMI_OFF_SUPV:  n.supv = wv;
        `SLMI_OFF_TRIG: begin
          n.meas_busy = 1'b1;
          n.meas_trig = 1'b1;
        end
        `SLMI_OFF_PTSEL: n.pt_sel = wv[9:0];
        default: ;
      endcase
    end
    // Pending commands take effect together on execute
    if (exec) begin
      if (r.pend_hv) n.hv_en = r.pend_hv_val;
      if (r.pend_dd) n.dd_en = r.pend_dd_val;
      if (r.pend_sup) n.sup_en = r.pend_sup_val;
      if (r.pend_restore) begin
        n.first_idx = `SLMI_INDEX_RST;
        n.last_idx  = `SLMI_INDEX_RST;
      end
      if (r.pend_mod) begin
        if (!r.cmd.has_first) begin
          n.err[`SLMI_ERR_ILLEGAL_BIT] = 1'b1;
        end else if (r.cmd.first < `SLMI_MIN_INDEX || r.cmd.first > `SLMI_MAX_INDEX ||
                     lst < r.cmd.first || lst > `SLMI_MAX_INDEX) begin
          n.err[`SLMI_ERR_ILLEGAL_BIT] = 1'b1;
        end else if ((r.cmd.has_delay && r.cmd.delay > `SLMI_MAX_DELAY) ||
                     (r.cmd.has_range && chk.range_bad)) begin
          n.err[`SLMI_ERR_ILLEGAL_BIT] = 1'b1;
        end else if (r.cmd.has_level && chk.level_bad) begin
          n.err[`SLMI_ERR_VALUE_BIT] = 1'b1;
        end else if (lst > {21'h0, r.sweep_size}) begin
          n.warn[`SLMI_WRN_CREATE_BIT] = 1'b1;
        end else begin
          n.first_idx = r.cmd.first[9:0];
          n.last_idx  = lst[9:0];
          n.ap        = r.cmd;
          n.idx       = r.cmd.first[9:0] - 10'h001;
          n.stop      = lst[9:0] - 10'h001;
          n.state     = SLMI_APPLY;
          if (r.pulsed) n.recalc = 1'b0;
        end
      end
    end
    if (exec || DEV_CLEAR) begin
      // Device clear drops staging but keeps the indices
      {n.pend_mod, n.pend_hv, n.pend_dd, n.pend_sup, n.pend_restore} = 5'h00;
      {n.cmd.has_level, n.cmd.has_range, n.cmd.has_delay} = 3'h0;
      {n.cmd.has_first, n.cmd.has_last} = 2'h0;
    end
    // One point per cycle from first through last
    unique case (r.state)
      SLMI_IDLE: ;
      SLMI_APPLY: begin
        if (r.ap.has_level) begin
          if (r.ap.has_range) begin
            p.level      = r.ap.level;
            p.range_code = (r.ap.range_code[3:0] == 4'h0) ? chk.auto_range
                                                           : r.ap.range_code[3:0];
          end else if (chk.fits_present) begin
            p.level = r.ap.level;
          end else begin
            n.warn[`SLMI_WRN_RANGE_BIT] = 1'b1;
          end
        end else if (r.ap.has_range) begin
          p.range_code = (r.ap.range_code[3:0] == 4'h0) ? chk.auto_range
                                                         : r.ap.range_code[3:0];
        end
        if (r.ap.has_delay) p.delay = r.ap.delay[15:0];
        n.pts[r.idx] = p;
        if (r.idx == r.stop) n.state = SLMI_IDLE;
        else n.idx = r.idx + 10'h001;
      end
    endcase
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      n.ar_addr = S_AXI_ARADDR;
      n.ar_have = 1'b1;
    end
    if (r.rvalid && S_AXI_RREADY) n.rvalid = 1'b0;
    if (r.ar_have && !r.rvalid && !(r.ar_addr == `SLMI_OFF_READING && r.meas_busy)) begin
      n.ar_have = 1'b0;
      n.rvalid  = 1'b1;
      n.rdata   = mapped(r.ar_addr) ? image(r.ar_addr) : 32'h0;
      n.rresp   = mapped(r.ar_addr) ? `SLMI_RESP_OKAY : `SLMI_RESP_SLV;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      r           <= '0;
      r.first_idx <= `SLMI_INDEX_RST;
      r.last_idx  <= `SLMI_INDEX_RST;
      r.recalc    <= 1'b1;
    end else begin
      r <= n;
    end
  end

endmodule

// file: tb/slmi_chk.sv
`timescale 1ns/1ps
module slmi_chk (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // Bus and trigger
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        MEAS_TRIG
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_bad; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h4c; endsequence
  sequence s_ok;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR <= 8'h4c
      && S_AXI_ARADDR[1:0] == 2'h0 && S_AXI_ARADDR != 8'h3c;
  endsequence
  sequence s_err; S_AXI_RVALID && S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0; endsequence
  // Address is held one cycle before the answer is registered
  chk_bad_read: assert property (s_bad |=> ##1 s_err)
    else $error("unmapped read not refused");
  chk_read_answer: assert property (s_ok |=> ##1 S_AXI_RVALID && S_AXI_RRESP == 2'h0)
    else $error("read answer late or wrong");
  chk_r_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
    && $stable(S_AXI_RDATA)) else $error("read data dropped");
  chk_r_ends: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read answer repeated");
  chk_b_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
    && $stable(S_AXI_BRESP)) else $error("write response dropped");
  chk_b_blocks: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken during response");
  chk_ar_blocks: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken during answer");
  chk_trig_pulse: assert property (MEAS_TRIG |=> !MEAS_TRIG)
    else $error("trigger longer than a cycle");
endmodule
bind slmi_top slmi_chk u_chk (.CLK, .RST, .S_AXI_AWREADY, .S_AXI_WREADY, .S_AXI_BRESP,
  .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .MEAS_TRIG);

// file: tb/slmi_meas_model.sv
`timescale 1ns/1ps
module slmi_meas_model #(
  parameter int          LAT    = 12,
  parameter logic [31:0] RESULT = 32'h5a5a_0001
) (
  // Clock and reset
  input wire logic   CLK,
  input wire logic   RST,
  // Measurement path
  input wire logic   MEAS_TRIG,
  output logic       MEAS_VALID,
  output logic [31:0] MEAS_DATA
);
  int cnt;
  // Data toggles outside the valid cycle so a stale capture shows
  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt <= 0;
      MEAS_VALID <= 1'b0;
      MEAS_DATA <= 32'h0;
    end else begin
      MEAS_VALID <= cnt == 1;
      MEAS_DATA <= (cnt == 1) ? RESULT : ~MEAS_DATA;
      if (MEAS_TRIG) cnt <= LAT;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule

// file: tb/slmi_top_tb.sv
`timescale 1ns/1ps
module slmi_top_tb import slmi_pkg::*;;
  logic        CLK, RST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic        S_AXI_RREADY, DEV_CLEAR, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic        S_AXI_ARREADY, S_AXI_RVALID, MEAS_TRIG, MEAS_VALID;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, MEAS_DATA, rdat;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic [31:0] cd [4] = '{32'h5, 32'h7, 32'ha, 32'hb};
  slmi_ext_t   EXT_STATUS;
  int          err_total, total_checks, i;
  slmi_top u_dut (.CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .DEV_CLEAR, .MEAS_TRIG, .MEAS_VALID,
    .MEAS_DATA, .EXT_STATUS);
  slmi_meas_model u_meas (.CLK, .RST, .MEAS_TRIG, .MEAS_VALID, .MEAS_DATA);
  // ----
  // Bus tasks
  // ----
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task tmo;
    err_total++;
    $display("ERROR %0t bus wait ran out", $time);
    end_of_test;
  endtask
  // Sampling 1 ns after the edge keeps the handshake race free
  // Ready follows valid by a cycle so the answer must stand while stalled
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb, bv;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h6;
    tb = 1'b0;
    for (int n = 0; n < 2000 && !tb; n++) begin
      #1;
      ta = S_AXI_AWVALID && S_AXI_AWREADY;
      tw = S_AXI_WVALID && S_AXI_WREADY;
      tb = S_AXI_BVALID && S_AXI_BREADY;
      bv = S_AXI_BVALID;
      rsp = S_AXI_BRESP;
      @(posedge CLK);
      if (ta) S_AXI_AWVALID <= 1'b0;
      if (tw) S_AXI_WVALID <= 1'b0;
      S_AXI_BREADY <= bv && !tb;
    end
    if (!tb) tmo;
  endtask
  task rd(input logic [7:0] a);
    logic ta, tr, rv;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h2;
    tr = 1'b0;
    for (int n = 0; n < 2000 && !tr; n++) begin
      #1;
      ta = S_AXI_ARVALID && S_AXI_ARREADY;
      tr = S_AXI_RVALID && S_AXI_RREADY;
      rv = S_AXI_RVALID;
      rdat = S_AXI_RDATA;
      rsp = S_AXI_RRESP;
      @(posedge CLK);
      if (ta) S_AXI_ARVALID <= 1'b0;
      S_AXI_RREADY <= rv && !tr;
    end
    if (!tr) tmo;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    cmp(rdat, e);
  endtask
  task st(input logic [31:0] c, input logic [31:0] e);
    wr(8'h18, c);
    rc(8'h1c, e);
  endtask
  task pt(input logic [31:0] p, input logic [31:0] l, input logic [31:0] r);
    wr(8'h44, p);
    rc(8'h48, l);
    rc(8'h4c, r);
  endtask
  // Trailing write stalls until the point run has finished
  task ex(input logic [31:0] c);
    wr(8'h00, c);
    wr(8'h00, 32'h6);
    wr(8'h2c, 32'h0);
  endtask
  // ----
  // Stimulus
  // ----
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  initial begin
    RST = 1'b1;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
    DEV_CLEAR = 1'b0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
    EXT_STATUS = '{32'h11, 32'h22, 32'h33, 32'h44};
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rc(8'h40, 32'h0001_0001);
    st(32'h3, 32'h20);
    rd(8'h50);
    cmp({30'h0, rsp}, 32'h2);
    wr(8'h50, 32'h0);
    cmp({30'h0, rsp}, 32'h2);
    wr(8'h28, 32'h0003_0005);
    st(32'h8, 32'h5);
    wr(8'h04, 32'h001e_8480);
    wr(8'h08, 32'h2);
    wr(8'h10, 32'h2);
    wr(8'h00, 32'h1);
    pt(32'h1, 32'h0, 32'h0);
    ex(32'h0);
    pt(32'h1, 32'h001e_8480, 32'h0002_0000);
    pt(32'h2, 32'h0, 32'h0);
    st(32'h3, 32'h18);
    wr(8'h0c, 32'h96);
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h5);
    ex(32'h1);
    pt(32'h1, 32'h001e_8480, 32'h0002_0096);
    pt(32'h4, 32'h0, 32'h96);
    ex(32'h1);
    rc(8'h20, 32'h1);
    wr(8'h20, 32'h3);
    wr(8'h10, 32'h3e9);
    ex(32'h1);
    rc(8'h20, 32'h1);
    wr(8'h20, 32'h3);
    wr(8'h0c, 32'h7);
    wr(8'h10, 32'h4);
    wr(8'h14, 32'h6);
    ex(32'h1);
    rc(8'h24, 32'h1);
    pt(32'h3, 32'h0, 32'h96);
    rc(8'h40, 32'h0005_0002);
    wr(8'h24, 32'h3);
    wr(8'h0c, 32'hfde9);
    wr(8'h10, 32'h1);
    ex(32'h1);
    rc(8'h20, 32'h1);
    wr(8'h20, 32'h3);
    wr(8'h0c, 32'hfde8);
    wr(8'h10, 32'h1);
    ex(32'h1);
    pt(32'h0, 32'h0, 32'hfde8);
    wr(8'h08, 32'h4);
    wr(8'h10, 32'h1);
    ex(32'h1);
    rc(8'h20, 32'h1);
    wr(8'h20, 32'h3);
    wr(8'h04, 32'h068e_7781);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h1);
    ex(32'h1);
    rc(8'h20, 32'h2);
    wr(8'h20, 32'h3);
    wr(8'h04, 32'h001e_8480);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h3);
    ex(32'h1);
    pt(32'h2, 32'h001e_8480, 32'h0002_0096);
    wr(8'h04, 32'h0131_2d00);
    wr(8'h10, 32'h2);
    ex(32'h1);
    rc(8'h24, 32'h2);
    pt(32'h1, 32'h001e_8480, 32'h0002_0096);
    wr(8'h00, 32'h12);
    wr(8'h00, 32'h13);
    ex(32'h14);
    st(32'h3, 32'h1f);
    ex(32'h2);
    st(32'h3, 32'h1e);
    for (i = 0; i < 4; i++) st(cd[i], 32'(32'h11 * (i + 1)));
    wr(8'h38, 32'h0);
    rc(8'h3c, 32'h5a5a_0001);
    @(posedge CLK);
    DEV_CLEAR <= 1'b1;
    @(posedge CLK);
    DEV_CLEAR <= 1'b0;
    rc(8'h40, 32'h0002_0002);
    ex(32'h5);
    rc(8'h40, 32'h0001_0001);
    end_of_test;
  end
endmodule
